//--- design/cmpevt_top.sv
// Local design decisions: the plain strobed port and the address map.
module cmpevt_top
  import cmpevt_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        reset_n,
  input  wire cmpevt_pkg::cmpevt_bus_type  bus,
  output logic [7:0]                       rdata,
  input  wire logic [2:0]                  cmp_raw,
  output cmpevt_pkg::cmpevt_analog_type    analog1,
  output cmpevt_pkg::cmpevt_analog_type    analog2,
  output cmpevt_pkg::cmpevt_analog_type    analog3,
  input  wire logic                        timer_capture_edge_select,
  output logic                             timer_capture_event,
  output logic                             timer_capture_routed,
  input  wire logic [2:0]                  irq_ack,
  output logic [2:0]                       irq_req,
  output logic [2:0]                       conv_trigger,
  input  wire logic [7:0]                  pin_raw_low,
  input  wire logic [7:0]                  pin_raw_high,
  output logic [7:0]                       pin_in_low,
  output logic [7:0]                       pin_in_high,
  output logic [7:0]                       buf_enable_low,
  output logic [7:0]                       buf_enable_high
);
  import cmpevt_pkg::*;

  logic [7:0] ext_ctrl [NUM_CMP];
  logic [7:0] ctrl     [NUM_CMP];
  logic [7:0] dis_low;
  logic [7:0] dis_high;
  logic [2:0] flag;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] level_q;
  logic [2:0] level;
  logic [2:0] hit;
  logic [2:0] next_flag;
  logic [7:0] psync1_low;
  logic [7:0] psync2_low;
  logic [7:0] psync1_high;
  logic [7:0] psync2_high;
  logic       cap_prev;
  logic       cap_src;

  function automatic logic sens_hit(input logic [1:0] sel, input logic now, input logic was);
    case (cmpevt_sens_type'(sel))
      CMPEVT_SENS_TOGGLE: sens_hit = now ^ was;
      CMPEVT_SENS_FALL:   sens_hit = was & ~now;
      CMPEVT_SENS_RISE:   sens_hit = now & ~was;
      default:            sens_hit = 1'b0;
    endcase
  endfunction : sens_hit

  wire wr_status = bus.wr && (bus.addr == {1'b0, ADDR_STATUS});

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      sync1   <= 3'h0;
      sync2   <= 3'h0;
      level_q <= 3'h0;
    end
    else
    begin
      sync1   <= cmp_raw;
      sync2   <= sync1;
      level_q <= level;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_CMP; i++)
      level[i] = sync2[i] ^ ext_ctrl[i][BIT_INVERT];
  end

  // register writes
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CMP; i++)
      begin
        ext_ctrl[i] <= RESET_VALUE;
        ctrl[i]     <= RESET_VALUE;
      end
      dis_low  <= RESET_VALUE;
      dis_high <= RESET_VALUE;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        {1'b0, ADDR_EXT_CTRL1}: ext_ctrl[0] <= bus.wdata & EXT1_MASK;
        {1'b0, ADDR_EXT_CTRL2}: ext_ctrl[1] <= bus.wdata & EXT23_MASK;
        {1'b0, ADDR_EXT_CTRL3}: ext_ctrl[2] <= bus.wdata & EXT23_MASK;
        {1'b0, ADDR_CTRL1}:     ctrl[0] <= bus.wdata & CTRL_MASK;
        {1'b0, ADDR_CTRL2}:     ctrl[1] <= bus.wdata & CTRL_MASK;
        {1'b0, ADDR_CTRL3}:     ctrl[2] <= bus.wdata & CTRL_MASK;
        {1'b0, ADDR_DIS_LOW}:   dis_low <= bus.wdata;
        ADDR_DIS_HIGH:          dis_high <= bus.wdata & DIS_HIGH_MASK;
        default:                ;
      endcase
    end
  end

  // event flags; a new event beats a clear in the same cycle
  always_comb
  begin
    for (int i = 0; i < NUM_CMP; i++)
    begin
      hit[i] = sens_hit(ctrl[i][POS_SENS +: 2], level[i], level_q[i]);
      next_flag[i] = flag[i];
      if (wr_status && bus.wdata[POS_FLAG + i])
        next_flag[i] = 1'b0;
      if (irq_ack[i] && ctrl[i][BIT_IRQ_EN])
        next_flag[i] = 1'b0;
      if (hit[i])
        next_flag[i] = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      flag <= 3'h0;
    else
      flag <= next_flag;
  end

  assign irq_req[0] = flag[0] & ctrl[0][BIT_IRQ_EN];
  assign irq_req[1] = flag[1] & ctrl[1][BIT_IRQ_EN];
  assign irq_req[2] = flag[2] & ctrl[2][BIT_IRQ_EN];
  assign conv_trigger = flag;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      analog1 <= '0;
      analog2 <= '0;
      analog3 <= '0;
    end
    else
    begin
      analog1 <= '{ext_ctrl[0][POS_HYST +: 3], ext_ctrl[0][BIT_PIN_OE], ext_ctrl[0][BIT_PIN_OE] & level[0]};
      analog2 <= '{ext_ctrl[1][POS_HYST +: 3], ext_ctrl[1][BIT_PIN_OE], ext_ctrl[1][BIT_PIN_OE] & level[1]};
      analog3 <= '{ext_ctrl[2][POS_HYST +: 3], ext_ctrl[2][BIT_PIN_OE], ext_ctrl[2][BIT_PIN_OE] & level[2]};
    end
  end

  // gated source, zero when route is off
  assign cap_src = ext_ctrl[0][BIT_CAPTURE] & level[0];
  // interrupt masking stays in the timer
  assign timer_capture_routed = ext_ctrl[0][BIT_CAPTURE];

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cap_prev            <= 1'b0;
      timer_capture_event <= 1'b0;
    end
    else
    begin
      cap_prev            <= cap_src;
      timer_capture_event <= ext_ctrl[0][BIT_CAPTURE] &&
                             (timer_capture_edge_select ? (cap_src & ~cap_prev) : (~cap_src & cap_prev));
    end
  end

  // port pin synchronisers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      psync1_low  <= 8'h00;
      psync2_low  <= 8'h00;
      psync1_high <= 8'h00;
      psync2_high <= 8'h00;
    end
    else
    begin
      psync1_low  <= pin_raw_low;
      psync2_low  <= psync1_low;
      psync1_high <= pin_raw_high;
      psync2_high <= psync1_high;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pin_in_low  <= 8'h00;
      pin_in_high <= 8'h00;
    end
    else
    begin
      pin_in_low  <= psync2_low & ~dis_low;
      pin_in_high <= psync2_high & ~dis_high;
    end
  end
  assign buf_enable_low  = ~dis_low;
  assign buf_enable_high = ~dis_high;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      case (bus.addr)
        {1'b0, ADDR_EXT_CTRL1}: rdata <= ext_ctrl[0];
        {1'b0, ADDR_EXT_CTRL2}: rdata <= ext_ctrl[1];
        {1'b0, ADDR_EXT_CTRL3}: rdata <= ext_ctrl[2];
        {1'b0, ADDR_CTRL1}:     rdata <= ctrl[0];
        {1'b0, ADDR_CTRL2}:     rdata <= ctrl[1];
        {1'b0, ADDR_CTRL3}:     rdata <= ctrl[2];
        {1'b0, ADDR_STATUS}:    rdata <= {flag, 1'b0, sync2, 1'b0};
        {1'b0, ADDR_DIS_LOW}:   rdata <= dis_low;
        ADDR_DIS_HIGH:          rdata <= dis_high;
        default:                rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  property p_flag_set;
    @(posedge mclk) disable iff (!reset_n) hit[0] |=> flag[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

  property p_w1c;
    @(posedge mclk) disable iff (!reset_n)
      (wr_status && bus.wdata[POS_FLAG + 1] && !hit[1]) |=> !flag[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_w0_keeps;
    @(posedge mclk) disable iff (!reset_n)
      (flag[2] && !(wr_status && bus.wdata[POS_FLAG + 2]) && !irq_ack[2]) |=> flag[2];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("flag lost without clear");

  property p_ack_clear;
    @(posedge mclk) disable iff (!reset_n)
      (irq_ack[0] && ctrl[0][BIT_IRQ_EN] && !hit[0]) |=> !flag[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear flag");

  property p_irq_gate;
    @(posedge mclk) disable iff (!reset_n) irq_req[1] |-> (flag[1] && ctrl[1][BIT_IRQ_EN]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable and flag");

  property p_no_route;
    @(posedge mclk) disable iff (!reset_n) !ext_ctrl[0][BIT_CAPTURE] |=> !timer_capture_event;
  endproperty
  a_no_route: assert property (p_no_route) else $error("capture event with route off");

  property p_rise_capture;
    @(posedge mclk) disable iff (!reset_n)
      (ext_ctrl[0][BIT_CAPTURE] && timer_capture_edge_select && cap_src && !cap_prev) |=> timer_capture_event;
  endproperty
  a_rise_capture: assert property (p_rise_capture) else $error("rising capture missed");

  property p_level_read;
    @(posedge mclk) disable iff (!reset_n)
      (bus.rd && bus.addr == {1'b0, ADDR_STATUS}) |=> rdata[POS_LEVEL +: 3] == $past(sync2);
  endproperty
  a_level_read: assert property (p_level_read) else $error("level readback wrong");

  property p_pin_off;
    @(posedge mclk) disable iff (!reset_n) (dis_low[0] && $past(dis_low[0])) |-> !pin_in_low[0];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin reads one");

  property p_pin_oe;
    @(posedge mclk) disable iff (!reset_n) analog1.pin_out |-> analog1.pin_oe;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin driven while disabled");

  property p_invert_pin;
    @(posedge mclk) disable iff (!reset_n)
      (ext_ctrl[1][BIT_PIN_OE] && ext_ctrl[1][BIT_INVERT]) |=> analog2.pin_out == !$past(sync2[1]);
  endproperty
  a_invert_pin: assert property (p_invert_pin) else $error("inverted pin level wrong");

  property p_fall_capture;
    @(posedge mclk) disable iff (!reset_n)
      (ext_ctrl[0][BIT_CAPTURE] && !timer_capture_edge_select && !cap_src && cap_prev) |=> timer_capture_event;
  endproperty
  a_fall_capture: assert property (p_fall_capture) else $error("falling capture missed");

  property p_hyst_code;
    @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> analog3.hyst == $past(ext_ctrl[2][POS_HYST +: 3]);
  endproperty
  a_hyst_code: assert property (p_hyst_code) else $error("hysteresis code not passed on");

  property p_reserved_sens;
    @(posedge mclk) disable iff (!reset_n) (ctrl[2][POS_SENS +: 2] == 2'h1) |-> !hit[2];
  endproperty
  a_reserved_sens: assert property (p_reserved_sens) else $error("reserved sensitivity flagged");

  property p_high_off;
    @(posedge mclk) disable iff (!reset_n) (dis_high[3] && $past(dis_high[3])) |-> !pin_in_high[3];
  endproperty
  a_high_off: assert property (p_high_off) else $error("disabled high pin reads one");

  c_flag1: cover property (@(posedge mclk) disable iff (!reset_n) hit[0] ##1 flag[0]);
  c_capture: cover property (@(posedge mclk) disable iff (!reset_n) timer_capture_event);
  c_ack: cover property (@(posedge mclk) disable iff (!reset_n) irq_req[2] ##1 irq_ack[2]);
endmodule : cmpevt_top

//--- shared/cmpevt_pkg.sv
package cmpevt_pkg;
  localparam int          NUM_CMP          = 3;
  localparam logic [2:0]  ADDR_EXT_CTRL1   = 3'h0;
  localparam logic [2:0]  ADDR_EXT_CTRL2   = 3'h1;
  localparam logic [2:0]  ADDR_EXT_CTRL3   = 3'h2;
  localparam logic [2:0]  ADDR_CTRL1       = 3'h3;
  localparam logic [2:0]  ADDR_CTRL2       = 3'h4;
  localparam logic [2:0]  ADDR_CTRL3       = 3'h5;
  localparam logic [2:0]  ADDR_STATUS      = 3'h6;
  localparam logic [2:0]  ADDR_DIS_LOW     = 3'h7;
  localparam logic [3:0]  ADDR_DIS_HIGH    = 4'h8;
  // extended control fields
  localparam int          BIT_INVERT       = 5;
  localparam int          BIT_PIN_OE       = 4;
  localparam int          BIT_CAPTURE      = 3;
  localparam int          POS_HYST         = 0;
  localparam logic [7:0]  EXT_MASK         = 8'h3f;
  localparam logic [7:0]  EXT1_MASK        = 8'h3f;
  localparam logic [7:0]  EXT23_MASK       = 8'h37;
  // per-comparator control fields
  localparam int          BIT_IRQ_EN       = 6;
  localparam int          POS_SENS         = 4;
  localparam logic [7:0]  CTRL_MASK        = 8'h70;
  // status fields
  localparam int          POS_FLAG         = 5;
  localparam int          POS_LEVEL        = 1;
  localparam logic [7:0]  DIS_HIGH_MASK    = 8'h09;
  localparam logic [7:0]  RESET_VALUE      = 8'h00;
  typedef enum logic [1:0] {
    CMPEVT_SENS_TOGGLE   = 2'h0,
    CMPEVT_SENS_RESERVED = 2'h1,
    CMPEVT_SENS_FALL     = 2'h2,
    CMPEVT_SENS_RISE     = 2'h3
  } cmpevt_sens_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cmpevt_bus_type;
  typedef struct packed {
    logic [2:0] hyst;
    logic       pin_oe;
    logic       pin_out;
  } cmpevt_analog_type;
endpackage : cmpevt_pkg

//--- tb/cmpevt_partner.sv
module cmpevt_partner (
  input  wire logic       mclk,
  input  wire logic       timer_capture_event,
  output logic      [2:0] cmp_raw,
  output logic            timer_capture_edge_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_mask  = 1'b0;
  int   cap_count = 0;
  int   irq_count = 0;
  initial
  begin
    cmp_raw = 3'h0;
    timer_capture_edge_select = 1'b0;
  end
  always @(posedge mclk)
  begin
    cap_count <= cap_count + int'(timer_capture_event);
    irq_count <= irq_count + int'(timer_capture_event & irq_mask);
  end
  task automatic set_raw(input logic [2:0] r);
    @(posedge mclk);
    cmp_raw <= r;
  endtask : set_raw
  // edge select level held by timer
  task automatic set_timer(input logic es, input logic m);
    @(posedge mclk);
    timer_capture_edge_select <= es;
    irq_mask <= m;
  endtask : set_timer
endmodule : cmpevt_partner

//--- tb/tb_cmpevt_top.sv
module tb_cmpevt_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmpevt_pkg::*;
  logic              mclk, reset_n, edge_sel, cap_ev, routed;
  cmpevt_bus_type    bus;
  cmpevt_analog_type an [0:2];
  logic [7:0]        rdata, raw_lo, raw_hi, in_lo, in_hi, ben_lo, ben_hi, d;
  logic [2:0]        cmp_raw, irq_ack, irq_req, conv, mflag, men, lvl, minv;
  logic [1:0]        msens [0:2];
  logic [31:0]       lfsr = 32'h0001766c;
  int                err_total = 0;
  int                tests_run = 0;
  int                cc, ss, iv, c0, i0;
  cmpevt_top u_cmpevt_top (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .cmp_raw(cmp_raw),
    .analog1(an[0]), .analog2(an[1]), .analog3(an[2]), .timer_capture_edge_select(edge_sel),
    .timer_capture_event(cap_ev), .timer_capture_routed(routed), .irq_ack(irq_ack), .irq_req(irq_req),
    .conv_trigger(conv), .pin_raw_low(raw_lo), .pin_raw_high(raw_hi), .pin_in_low(in_lo),
    .pin_in_high(in_hi), .buf_enable_low(ben_lo), .buf_enable_high(ben_hi));
  cmpevt_partner u_cmpevt_partner (.mclk(mclk), .timer_capture_event(cap_ev), .cmp_raw(cmp_raw),
    .timer_capture_edge_select(edge_sel));
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] rmask(input int a);
    case (a)
      0: return EXT1_MASK;
      1, 2: return EXT23_MASK;
      3, 4, 5: return CTRL_MASK;
      7: return 8'hff;
      8: return DIS_HIGH_MASK;
      default: return 8'h00;
    endcase
  endfunction : rmask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("err_total %0d tests_run %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1;
    v = rdata;
  endtask : rd
  task automatic chk_status;
    logic [7:0] v;
    rd(4'(ADDR_STATUS), v);
    check(v, {mflag, 1'b0, lvl, 1'b0});
    check({5'h0, conv}, {5'h0, mflag});
    check({5'h0, irq_req}, {5'h0, mflag & men});
  endtask : chk_status
  // model: flag on edge of inverted level that matches sensitivity
  task automatic raw_to(input logic [2:0] r);
    logic [2:0] rise;
    logic [2:0] fall;
    rise = (r ^ minv) & ~(lvl ^ minv);
    fall = ~(r ^ minv) & (lvl ^ minv);
    u_cmpevt_partner.set_raw(r);
    repeat (5) @(posedge mclk);
    for (int c = 0; c < 3; c++)
      if ((rise[c] && msens[c] != 2'h1 && msens[c] != 2'h2) || (fall[c] && !msens[c][0]))
        mflag[c] = 1'b1;
    lvl = r;
  endtask : raw_to
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    wrap_up;
  end
  initial
  begin
    reset_n = 1'b0;
    bus = '0;
    irq_ack = 3'h0;
    raw_lo = 8'h00;
    raw_hi = 8'h00;
    {mflag, men, lvl, minv} = 12'h000;
    msens = '{2'h0, 2'h0, 2'h0};
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    for (int a = 0; a < 16; a++)
    begin
      rd(4'(a), d);
      check(d, 8'h00);
    end
    check(ben_lo, 8'hff);
    for (int i = 0; i < 27; i++)
    begin
      lfsr = lfsr_next(lfsr);
      if (i % 9 == 6)
        continue;
      wr(4'(i % 9), lfsr[7:0]);
      rd(4'(i % 9), d);
      check(d, lfsr[7:0] & rmask(i % 9));
      if (i % 9 < 3)
        check({4'h0, an[i % 9].pin_oe, an[i % 9].hyst}, {4'h0, lfsr[4], lfsr[2:0]});
    end
    for (int h = 0; h < 8; h++)
    begin
      wr(4'(h % 3), 8'(h));
      repeat (2) @(posedge mclk);
      #1 check({5'h0, an[h % 3].hyst}, 8'(h));
    end
    lfsr = lfsr_next(lfsr);
    wr(4'(ADDR_DIS_LOW), lfsr[7:0]);
    wr(4'(ADDR_DIS_HIGH), lfsr[15:8]);
    raw_lo <= lfsr[23:16];
    raw_hi <= lfsr[31:24];
    repeat (4) @(posedge mclk);
    #1;
    check(in_lo, lfsr[23:16] & ~lfsr[7:0]);
    check(ben_lo, ~lfsr[7:0]);
    check(in_hi, lfsr[31:24] & ~(lfsr[15:8] & DIS_HIGH_MASK));
    check(ben_hi, ~(lfsr[15:8] & DIS_HIGH_MASK));
    for (int a = 0; a < 6; a++)
      wr(4'(a), 8'h00);
    for (int k = 0; k < 24; k++)
    begin
      cc = k % 3;
      ss = (k / 3) % 4;
      iv = k / 12;
      minv[cc] = iv[0];
      msens[cc] = ss[1:0];
      men[cc] = 1'b1;
      wr(4'(ADDR_EXT_CTRL1 + cc), {2'h0, iv[0], 1'b1, 4'h0});
      wr(4'(ADDR_CTRL1 + cc), {2'h1, ss[1:0], 4'h0});
      // invert change alone may flag, so flush it
      repeat (4) @(posedge mclk);
      wr(4'(ADDR_STATUS), 8'he0);
      mflag = 3'h0;
      raw_to(lvl ^ (3'h1 << cc));
      chk_status;
      check({7'h0, an[cc].pin_out}, {7'h0, lvl[cc] ^ iv[0]});
      raw_to(lvl ^ (3'h1 << cc));
      chk_status;
    end
    wr(4'(ADDR_CTRL1), 8'h40);
    wr(4'(ADDR_CTRL2), 8'h40);
    wr(4'(ADDR_CTRL3), 8'h00);
    {men, msens[0], msens[1], msens[2]} = 9'h0c0;
    raw_to(3'h7);
    chk_status;
    wr(4'(ADDR_STATUS), 8'h00);
    chk_status;
    @(posedge mclk);
    irq_ack <= 3'h7;
    @(posedge mclk);
    irq_ack <= 3'h0;
    mflag = mflag & ~men;
    chk_status;
    wr(4'(ADDR_STATUS), 8'h80);
    mflag = 3'h0;
    chk_status;
    for (int m = 0; m < 4; m++)
    begin
      wr(4'(ADDR_EXT_CTRL1), {4'h0, m[1], 3'h0});
      minv[0] = 1'b0;
      u_cmpevt_partner.set_timer(m[0], m[0]);
      repeat (4) @(posedge mclk);
      c0 = u_cmpevt_partner.cap_count;
      i0 = u_cmpevt_partner.irq_count;
      check({7'h0, routed}, {7'h0, m[1]});
      raw_to(lvl & 3'h6);
      check(8'(u_cmpevt_partner.cap_count - c0), {7'h0, m[1] & ~m[0]});
      raw_to(lvl | 3'h1);
      check(8'(u_cmpevt_partner.cap_count - c0), {7'h0, m[1]});
      check(8'(u_cmpevt_partner.irq_count - i0), {7'h0, m[1] & m[0]});
    end
    wrap_up;
  end
endmodule : tb_cmpevt_top
